// ===== pfc_channel.sv
// One channel: clock source selection and phase compensation stages
`timescale 1ns/1ns
module pfc_channel
    import pfc_pkg::*;
#(
    parameter int DW = 16
) (
    input  wire logic          i_clk,         // System clock
    input  wire logic          i_reset_n,     // Sync reset, active low
    input  wire logic [2:0]    i_tx_sel,      // One-hot transmit source
    input  wire logic [3:0]    i_rx_sel,      // One-hot receive source
    input  wire logic          i_tx_clk0,     // Channel 0 transmit output clock
    input  wire logic          i_tx_clkout,   // Own transmit output clock
    input  wire logic          i_rx_clkout,   // Own receive output clock
    input  wire logic          i_tx_coreclk,  // Fabric transmit core clock
    input  wire logic          i_rx_coreclk,  // Fabric receive core clock
    input  wire logic [DW-1:0] i_tx_data,     // Fabric parallel data
    input  wire logic [DW-1:0] i_rx_data,     // Receive path parallel data
    output logic               o_tx_wrclk,    // Selected FIFO write clock
    output logic               o_rx_rdclk,    // Selected FIFO read clock
    output logic [DW-1:0]      o_tx_data,     // Data written into transmit FIFO
    output logic               o_tx_wr,       // Write strobe
    output logic [DW-1:0]      o_rx_data,     // Data read toward fabric
    output logic               o_rx_rd        // Read strobe
);
    logic          tx_clk_q, tx_clk_d, rx_clk_q, rx_clk_d;
    logic          tx_wr_q, tx_wr_d, rx_rd_q, rx_rd_d;
    logic [DW-1:0] tx_data_q, tx_data_d, rx_data_q, rx_data_d;

    always_comb begin
        // AND-OR mux: the one-hot select can never merge two sources
        tx_clk_d = (i_tx_sel[0] & i_tx_clk0)
                 | (i_tx_sel[1] & i_tx_clkout)
                 | (i_tx_sel[2] & i_tx_coreclk);
        rx_clk_d = (i_rx_sel[0] & i_tx_clk0)
                 | (i_rx_sel[1] & i_tx_clkout)
                 | (i_rx_sel[2] & i_rx_clkout)
                 | (i_rx_sel[3] & i_rx_coreclk);
        tx_wr_d   = tx_clk_d & ~tx_clk_q;
        rx_rd_d   = rx_clk_d & ~rx_clk_q;
        tx_data_d = tx_wr_d ? i_tx_data : tx_data_q;
        rx_data_d = rx_rd_d ? i_rx_data : rx_data_q;
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            tx_clk_q  <= 1'h0;
            rx_clk_q  <= 1'h0;
            tx_wr_q   <= 1'h0;
            rx_rd_q   <= 1'h0;
            tx_data_q <= '0;
            rx_data_q <= '0;
        end else begin
            tx_clk_q  <= tx_clk_d;
            rx_clk_q  <= rx_clk_d;
            tx_wr_q   <= tx_wr_d;
            rx_rd_q   <= rx_rd_d;
            tx_data_q <= tx_data_d;
            rx_data_q <= rx_data_d;
        end
    end

    assign o_tx_wrclk = tx_clk_q;
    assign o_rx_rdclk = rx_clk_q;
    assign o_tx_wr    = tx_wr_q;
    assign o_rx_rd    = rx_rd_q;
    assign o_tx_data  = tx_data_q;
    assign o_rx_data  = rx_data_q;
endmodule : pfc_channel

// ===== pfc_core_clock_select.sv
// Core clock selector top with AXI4-Lite register slave
`timescale 1ns/1ns
module pfc_core_clock_select
    import pfc_pkg::*;
#(
    parameter int N_CH = 4,
    parameter int DW   = 16
) (
    input  wire logic               i_clk,           // 20 MHz system clock
    input  wire logic               i_reset_n,       // Sync reset, active low
    input  wire logic [AXI_AW-1:0]  i_awaddr,        // Write address
    input  wire logic               i_awvalid,       // Write address valid
    output logic                    o_awready,       // Write address ready
    input  wire logic [AXI_DW-1:0]  i_wdata,         // Write data
    input  wire logic [3:0]         i_wstrb,         // Write byte strobes
    input  wire logic               i_wvalid,        // Write data valid
    output logic                    o_wready,        // Write data ready
    output logic [1:0]              o_bresp,         // Write response
    output logic                    o_bvalid,        // Write response valid
    input  wire logic               i_bready,        // Write response ready
    input  wire logic [AXI_AW-1:0]  i_araddr,        // Read address
    input  wire logic               i_arvalid,       // Read address valid
    output logic                    o_arready,       // Read address ready
    output logic [AXI_DW-1:0]       o_rdata,         // Read data
    output logic [1:0]              o_rresp,         // Read response
    output logic                    o_rvalid,        // Read data valid
    input  wire logic               i_rready,        // Read data ready
    input  wire logic [N_CH-1:0]    i_tx_clkout,     // Transmit output clocks
    input  wire logic [N_CH-1:0]    i_rx_clkout,     // Receive output clocks
    input  wire logic [N_CH-1:0]    i_tx_coreclk,    // Fabric transmit core clocks
    input  wire logic [N_CH-1:0]    i_rx_coreclk,    // Fabric receive core clocks
    input  wire logic [N_CH*DW-1:0] i_tx_data,       // Fabric data per channel
    input  wire logic [N_CH*DW-1:0] i_rx_data,       // Receive data per channel
    output logic [N_CH-1:0]         o_tx_wrclk,      // Transmit FIFO write clocks
    output logic [N_CH-1:0]         o_rx_rdclk,      // Receive FIFO read clocks
    output logic [N_CH*DW-1:0]      o_tx_data,       // Data into transmit FIFOs
    output logic [N_CH-1:0]         o_tx_wr,         // Transmit FIFO write strobes
    output logic [N_CH*DW-1:0]      o_rx_data,       // Data out of receive FIFOs
    output logic [N_CH-1:0]         o_rx_rd          // Receive FIFO read strobes
);
    if (N_CH < 1 || N_CH > 8 || DW < 1) begin : g_bad_param
        $error("pfc_core_clock_select: N_CH must be 1..8 and DW at least 1");
    end

    function automatic logic [2:0] tx_decode(input logic shared_n, input logic core);
        if (core)
            tx_decode = TX_SEL_CORE;
        else if (shared_n)
            tx_decode = TX_SEL_OWN;
        else
            tx_decode = TX_SEL_SHARED;
    endfunction : tx_decode

    function automatic logic [3:0] rx_decode(input logic [1:0] code, input logic core);
        if (core)
            rx_decode = RX_SEL_CORE;
        else if (code == RX_CODE_SHARED)
            rx_decode = RX_SEL_SHARED;
        else if (code == RX_CODE_OWN_TX)
            rx_decode = RX_SEL_OWN_TX;
        else
            rx_decode = RX_SEL_OWN_RX;
    endfunction : rx_decode

    // Write channel state
    pfc_wr_state_type        wr_state_q, wr_state_d;
    logic                    aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [AXI_AW-1:0]       awaddr_q, awaddr_d;
    logic [AXI_DW-1:0]       wdata_q, wdata_d;
    logic [3:0]              wstrb_q, wstrb_d;
    logic [1:0]              bresp_q, bresp_d;
    // Configuration and active selection
    logic [CFG_WIDTH-1:0]    cfg_q, cfg_d;
    logic [2:0]              tx_sel_q, tx_sel_d;
    logic [3:0]              rx_sel_q, rx_sel_d;
    logic                    bad_q, bad_d;
    logic [7:0]              apply_cnt_q, apply_cnt_d;
    logic                    do_write, apply_req;
    // Read channel state
    pfc_rd_state_type        rd_state_q, rd_state_d;
    logic [AXI_DW-1:0]       rdata_q, rdata_d;
    logic [1:0]              rresp_q, rresp_d;
    logic [AXI_DW-1:0]       status_word;

    always_comb begin
        wr_state_d = wr_state_q;
        aw_have_d  = aw_have_q;
        w_have_d   = w_have_q;
        awaddr_d   = awaddr_q;
        wdata_d    = wdata_q;
        wstrb_d    = wstrb_q;
        bresp_d    = bresp_q;
        do_write   = 1'b0;
        // Address and data are taken in either order, then answered once
        if (o_awready && i_awvalid) begin
            aw_have_d = 1'b1;
            awaddr_d  = i_awaddr;
        end
        if (o_wready && i_wvalid) begin
            w_have_d = 1'b1;
            wdata_d  = i_wdata;
            wstrb_d  = i_wstrb;
        end
        case (wr_state_q)
            WR_IDLE: begin
                if (aw_have_q && w_have_q) begin
                    do_write   = 1'b1;
                    aw_have_d  = 1'b0;
                    w_have_d   = 1'b0;
                    wr_state_d = WR_RESP;
                    if (awaddr_q == ADDR_CFG || awaddr_q == ADDR_APPLY)
                        bresp_d = RESP_OKAY;
                    else
                        bresp_d = RESP_SLVERR;
                end
            end
            WR_RESP: begin
                if (i_bready)
                    wr_state_d = WR_IDLE;
            end
            default: wr_state_d = WR_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            wr_state_q <= WR_IDLE;
            aw_have_q  <= 1'b0;
            w_have_q   <= 1'b0;
            awaddr_q   <= '0;
            wdata_q    <= '0;
            wstrb_q    <= 4'h0;
            bresp_q    <= RESP_OKAY;
        end else begin
            wr_state_q <= wr_state_d;
            aw_have_q  <= aw_have_d;
            w_have_q   <= w_have_d;
            awaddr_q   <= awaddr_d;
            wdata_q    <= wdata_d;
            wstrb_q    <= wstrb_d;
            bresp_q    <= bresp_d;
        end
    end

    assign o_awready = (wr_state_q == WR_IDLE) && !aw_have_q;
    assign o_wready  = (wr_state_q == WR_IDLE) && !w_have_q;
    assign o_bvalid  = (wr_state_q == WR_RESP);
    assign o_bresp   = bresp_q;

    assign apply_req = do_write && awaddr_q == ADDR_APPLY && wstrb_q[0] && wdata_q[APPLY_BIT];

    always_comb begin
        cfg_d       = cfg_q;
        tx_sel_d    = tx_sel_q;
        rx_sel_d    = rx_sel_q;
        bad_d       = bad_q;
        apply_cnt_d = apply_cnt_q;
        // Staged only; the running channels see nothing until an apply
        if (do_write && awaddr_q == ADDR_CFG && wstrb_q[0])
            cfg_d = wdata_q[CFG_WIDTH-1:0];
        if (apply_req) begin
            // Undefined receive code is refused so the old clocks keep running
            if (cfg_q[CFG_RX_SEL_LSB +: 2] == 2'h3 && !cfg_q[CFG_RX_CORE_BIT]) begin
                bad_d = 1'b1;
            end else begin
                bad_d       = 1'b0;
                tx_sel_d    = tx_decode(cfg_q[CFG_TX_SEL_BIT], cfg_q[CFG_TX_CORE_BIT]);
                rx_sel_d    = rx_decode(cfg_q[CFG_RX_SEL_LSB +: 2],
                                        cfg_q[CFG_RX_CORE_BIT]);
                apply_cnt_d = apply_cnt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cfg_q       <= CFG_RESET;
            tx_sel_q    <= TX_SEL_RESET;
            rx_sel_q    <= RX_SEL_RESET;
            bad_q       <= 1'b0;
            apply_cnt_q <= 8'h00;
        end else begin
            cfg_q       <= cfg_d;
            tx_sel_q    <= tx_sel_d;
            rx_sel_q    <= rx_sel_d;
            bad_q       <= bad_d;
            apply_cnt_q <= apply_cnt_d;
        end
    end

    always_comb begin
        status_word                       = '0;
        status_word[ST_TX_LSB +: 3]       = tx_sel_q;
        status_word[ST_RX_LSB +: 4]       = rx_sel_q;
        status_word[ST_BAD_BIT]           = bad_q;
        status_word[ST_CNT_LSB +: 8]      = apply_cnt_q;
    end

    always_comb begin
        rd_state_d = rd_state_q;
        rdata_d    = rdata_q;
        rresp_d    = rresp_q;
        case (rd_state_q)
            RD_IDLE: begin
                if (i_arvalid) begin
                    rd_state_d = RD_DATA;
                    rresp_d    = RESP_OKAY;
                    if (i_araddr == ADDR_CFG)
                        rdata_d = {{(AXI_DW-CFG_WIDTH){1'b0}}, cfg_q};
                    else if (i_araddr == ADDR_STATUS)
                        rdata_d = status_word;
                    else if (i_araddr == ADDR_APPLY)
                        rdata_d = '0;
                    else begin
                        rdata_d = '0;
                        rresp_d = RESP_SLVERR;
                    end
                end
            end
            RD_DATA: begin
                if (i_rready)
                    rd_state_d = RD_IDLE;
            end
            default: rd_state_d = RD_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            rd_state_q <= RD_IDLE;
            rdata_q    <= '0;
            rresp_q    <= RESP_OKAY;
        end else begin
            rd_state_q <= rd_state_d;
            rdata_q    <= rdata_d;
            rresp_q    <= rresp_d;
        end
    end

    assign o_arready = (rd_state_q == RD_IDLE);
    assign o_rvalid  = (rd_state_q == RD_DATA);
    assign o_rdata   = rdata_q;
    assign o_rresp   = rresp_q;

    // Fabric-supplied clocks are trusted to match the output clock rate
    for (genvar ch = 0; ch < N_CH; ch++) begin : g_ch
        pfc_channel #(
            .DW (DW)
        ) u_channel (
            .i_clk        (i_clk),
            .i_reset_n    (i_reset_n),
            .i_tx_sel     (tx_sel_q),
            .i_rx_sel     (rx_sel_q),
            .i_tx_clk0    (i_tx_clkout[0]),
            .i_tx_clkout  (i_tx_clkout[ch]),
            .i_rx_clkout  (i_rx_clkout[ch]),
            .i_tx_coreclk (i_tx_coreclk[ch]),
            .i_rx_coreclk (i_rx_coreclk[ch]),
            .i_tx_data    (i_tx_data[ch*DW +: DW]),
            .i_rx_data    (i_rx_data[ch*DW +: DW]),
            .o_tx_wrclk   (o_tx_wrclk[ch]),
            .o_rx_rdclk   (o_rx_rdclk[ch]),
            .o_tx_data    (o_tx_data[ch*DW +: DW]),
            .o_tx_wr      (o_tx_wr[ch]),
            .o_rx_data    (o_rx_data[ch*DW +: DW]),
            .o_rx_rd      (o_rx_rd[ch])
        );
    end
endmodule : pfc_core_clock_select

// ===== pfc_core_clock_select_bench.sv
// Self-checking bench for the core clock selector
`timescale 1ns/1ns
module pfc_core_clock_select_bench;
    import pfc_pkg::*;
    localparam int N_CH = 4;
    localparam int DW   = 16;
    logic               i_clk = 1'b0;
    logic               i_reset_n = 1'b0;
    logic [3:0]         i_awaddr = '0, i_araddr = '0, i_wstrb = 4'hF;
    logic [31:0]        i_wdata = '0, o_rdata;
    logic               i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
    logic               o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0]         o_bresp, o_rresp;
    logic [N_CH-1:0]    i_tx_clkout, i_rx_clkout, i_tx_coreclk, i_rx_coreclk;
    logic [N_CH-1:0]    o_tx_wrclk, o_rx_rdclk, o_tx_wr, o_rx_rd;
    logic [N_CH-1:0]    tx1, tx2, rx1, rx2, tc1, tc2, rc1, rc2;
    logic [N_CH*DW-1:0] i_tx_data, i_rx_data, o_tx_data, o_rx_data, td1, rd1;
    int                 fails = 0, checks_done = 0;

    pfc_fabric_model #(.N_CH(N_CH), .DW(DW)) u_pfc_fabric_model (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .o_tx_clkout(i_tx_clkout),
        .o_rx_clkout(i_rx_clkout), .o_tx_coreclk(i_tx_coreclk), .o_rx_coreclk(i_rx_coreclk),
        .o_tx_data(i_tx_data), .o_rx_data(i_rx_data));
    pfc_core_clock_select #(.N_CH(N_CH), .DW(DW)) u_pfc_core_clock_select (.*);

    always #25 i_clk = ~i_clk;
    // Sources as sampled at the last two edges
    always @(posedge i_clk) begin
        {tx1, rx1, tc1, rc1, td1, rd1} <= {i_tx_clkout, i_rx_clkout, i_tx_coreclk, i_rx_coreclk,
                                           i_tx_data, i_rx_data};
        {tx2, rx2, tc2, rc2} <= {tx1, rx1, tc1, rc1};
    end

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    task automatic give_up(input string nm);
        fails++;
        $display("[FAIL] %s expected handshake seen none", nm);
        wrap_up();
    endtask : give_up

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Mid-cycle look: ready settles after the edge, so the edge itself is a race
    task automatic tick(input string nm, inout int n);
        @(negedge i_clk);
        if (++n > 40) give_up(nm);
    endtask : tick

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int   n = 0;
        logic aw_ok = 1'b0, w_ok = 1'b0, aw_go, w_go;
        @(posedge i_clk);
        {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {a, d, 3'b111};
        while (!(aw_ok && w_ok)) begin
            tick("write request", n);
            aw_go = !aw_ok && o_awready;
            w_go  = !w_ok && o_wready;
            @(posedge i_clk);
            if (aw_go) i_awvalid <= 1'b0;
            if (w_go) i_wvalid <= 1'b0;
            aw_ok |= aw_go;
            w_ok  |= w_go;
        end
        do tick("write response", n); while (!o_bvalid);
        chk("bresp", 32'(er), 32'(o_bresp));
        @(posedge i_clk);
        i_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er,
                            input logic [31:0] m = 32'hFFFF_FFFF);
        int n = 0;
        @(posedge i_clk);
        {i_araddr, i_arvalid, i_rready} <= {a, 2'b11};
        do tick("read address", n); while (!o_arready);
        @(posedge i_clk);
        i_arvalid <= 1'b0;
        do tick("read data", n); while (!o_rvalid);
        chk("rdata", e, o_rdata & m);
        chk("rresp", 32'(er), 32'(o_rresp));
        @(posedge i_clk);
        i_rready <= 1'b0;
    endtask : axi_read

    function automatic logic tx_pick(int k, int ch, logic [N_CH-1:0] t, logic [N_CH-1:0] c);
        return (k == 0) ? t[0] : (k == 1) ? t[ch] : c[ch];
    endfunction : tx_pick

    function automatic logic rx_pick(int k, int ch, logic [N_CH-1:0] t, logic [N_CH-1:0] r,
                                     logic [N_CH-1:0] c);
        return (k == 0) ? t[0] : (k == 1) ? t[ch] : (k == 2) ? r[ch] : c[ch];
    endfunction : rx_pick

    // Slowest source has a 64-cycle period, so 80 cycles see every channel toggle
    task automatic watch(input int tk, input int rk);
        logic e, p;
        repeat (80) begin
            @(negedge i_clk);
            for (int ch = 0; ch < N_CH; ch++) begin
                e = tx_pick(tk, ch, tx1, tc1);
                p = tx_pick(tk, ch, tx2, tc2);
                chk("tx_wrclk", 32'(e), 32'(o_tx_wrclk[ch]));
                chk("tx_wr", 32'(e & ~p), 32'(o_tx_wr[ch]));
                if (e & ~p) chk("tx_data", 32'(td1[ch*DW +: DW]), 32'(o_tx_data[ch*DW +: DW]));
                e = rx_pick(rk, ch, tx1, rx1, rc1);
                p = rx_pick(rk, ch, tx2, rx2, rc2);
                chk("rx_rdclk", 32'(e), 32'(o_rx_rdclk[ch]));
                chk("rx_rd", 32'(e & ~p), 32'(o_rx_rd[ch]));
                if (e & ~p) chk("rx_data", 32'(rd1[ch*DW +: DW]), 32'(o_rx_data[ch*DW +: DW]));
            end
        end
    endtask : watch

    task automatic t_reset();
        axi_read(ADDR_CFG, 32'h0000_0002, RESP_OKAY);
        axi_read(ADDR_STATUS, 32'h0000_0042, RESP_OKAY);
        watch(1, 2);
    endtask : t_reset

    task automatic t_options();
        logic [5:0] cfg [5] = '{6'h00, 6'h03, 6'h05, 6'h30, 6'h35};
        int         tk [5] = '{0, 1, 1, 2, 2};
        int         rk [5] = '{0, 1, 2, 3, 3};
        for (int i = 0; i < 5; i++) begin
            axi_write(ADDR_CFG, 32'(cfg[i]), RESP_OKAY);
            axi_write(ADDR_APPLY, 32'h0000_0001, RESP_OKAY);
            axi_read(ADDR_CFG, 32'(cfg[i]), RESP_OKAY);
            axi_read(ADDR_STATUS, (32'(i + 1) << 16) | (32'h1 << tk[i]) | (32'h10 << rk[i]),
                     RESP_OKAY);
            watch(tk[i], rk[i]);
        end
    endtask : t_options

    // Invalid receive code is refused; a staged change without apply must not act
    task automatic t_refuse();
        axi_write(ADDR_CFG, 32'h0000_0006, RESP_OKAY);
        axi_write(ADDR_APPLY, 32'h0000_0001, RESP_OKAY);
        axi_read(ADDR_STATUS, 32'h0000_0184, RESP_OKAY, 32'h0000_01FF);
        axi_write(ADDR_CFG, 32'h0000_0000, RESP_OKAY);
        watch(2, 3);
    endtask : t_refuse

    task automatic t_bus();
        axi_write(4'hC, 32'h0000_0001, RESP_SLVERR);
        axi_read(4'hC, 32'h0000_0000, RESP_SLVERR);
        axi_read(ADDR_APPLY, 32'h0000_0000, RESP_OKAY);
        axi_write(ADDR_APPLY, 32'h0000_0000, RESP_OKAY);
        axi_read(ADDR_STATUS, 32'h0000_0084, RESP_OKAY, 32'h0000_00FF);
        watch(2, 3);
    endtask : t_bus

    initial begin
        repeat (12) @(posedge i_clk);
        i_reset_n <= 1'b1;
        t_reset();
        t_options();
        t_refuse();
        t_bus();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge i_clk);
        give_up("run time");
    end
endmodule : pfc_core_clock_select_bench

// ===== pfc_core_clock_select_sva.sv
// Port checker for the core clock selector
`timescale 1ns/1ns
module pfc_core_clock_select_sva
    import pfc_pkg::*;
#(
    parameter int N_CH = 4,
    parameter int DW   = 16
) (
    input wire logic               i_clk,      // Clock
    input wire logic               i_reset_n,  // Reset
    input wire logic               i_awvalid,  // AW valid
    input wire logic               o_awready,  // AW ready
    input wire logic               i_wvalid,   // W valid
    input wire logic               o_wready,   // W ready
    input wire logic [1:0]         o_bresp,    // B resp
    input wire logic               o_bvalid,   // B valid
    input wire logic               i_bready,   // B ready
    input wire logic               i_arvalid,  // AR valid
    input wire logic               o_arready,  // AR ready
    input wire logic [AXI_DW-1:0]  o_rdata,    // R data
    input wire logic               o_rvalid,   // R valid
    input wire logic               i_rready,   // R ready
    input wire logic [N_CH*DW-1:0] i_tx_data,  // Fabric data
    input wire logic [N_CH*DW-1:0] i_rx_data,  // Receive data
    input wire logic [N_CH-1:0]    o_tx_wrclk, // Write clocks
    input wire logic [N_CH*DW-1:0] o_tx_data,  // Write data
    input wire logic [N_CH-1:0]    o_tx_wr,    // Write strobes
    input wire logic [N_CH*DW-1:0] o_rx_data,  // Read data
    input wire logic [N_CH-1:0]    o_rx_rd     // Read strobes
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response not held");
    r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data not held");
    ar_block_a: assert property (o_rvalid |-> !o_arready)
        else $error("read address taken during read data");
    b_time_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready
        |=> !o_bvalid ##1 o_bvalid) else $error("write response timing");
    r_time_a: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read data timing");
    reset_out_a: assert property (disable iff (1'b0)
        !i_reset_n |=> !o_bvalid && !o_rvalid && o_tx_wr == '0 && o_rx_rd == '0
        && o_tx_wrclk == '0) else $error("outputs not cleared by reset");
    for (genvar c = 0; c < N_CH; c++) begin : g_ch
        tx_strobe_a: assert property (o_tx_wr[c] |-> o_tx_wrclk[c] ##1 !o_tx_wr[c])
            else $error("write strobe shape");
        tx_data_a: assert property (o_tx_wr[c]
            |-> o_tx_data[c*DW +: DW] == $past(i_tx_data[c*DW +: DW]))
            else $error("write data not captured");
        tx_hold_a: assert property (!o_tx_wr[c] |-> $stable(o_tx_data[c*DW +: DW]))
            else $error("write data moved without strobe");
        rx_strobe_a: assert property (o_rx_rd[c] |=> !o_rx_rd[c])
            else $error("read strobe longer than one cycle");
        rx_data_a: assert property (o_rx_rd[c]
            |-> o_rx_data[c*DW +: DW] == $past(i_rx_data[c*DW +: DW]))
            else $error("read data not captured");
    end
    wr_done_c: cover property (o_bvalid && i_bready);
    rd_done_c: cover property (o_rvalid && i_rready);
    tx_last_c: cover property (o_tx_wr[N_CH-1]);
    rx_last_c: cover property (o_rx_rd[N_CH-1]);
endmodule : pfc_core_clock_select_sva

bind pfc_core_clock_select pfc_core_clock_select_sva #(.N_CH(N_CH), .DW(DW)) u_sva (.*);

// ===== pfc_fabric_model.sv
// Fabric-side model: output clocks, core clocks and parallel data per channel
`timescale 1ns/1ns
module pfc_fabric_model #(
    parameter int N_CH = 4,
    parameter int DW   = 16
) (
    input  wire logic          i_clk,        // System clock
    input  wire logic          i_reset_n,    // Sync reset, active low
    output logic [N_CH-1:0]    o_tx_clkout,  // Transmit output clocks
    output logic [N_CH-1:0]    o_rx_clkout,  // Receive output clocks
    output logic [N_CH-1:0]    o_tx_coreclk, // Fabric transmit core clocks
    output logic [N_CH-1:0]    o_rx_coreclk, // Fabric receive core clocks
    output logic [N_CH*DW-1:0] o_tx_data,    // Fabric data
    output logic [N_CH*DW-1:0] o_rx_data     // Receive data
);
    logic [N_CH+1:0] cnt_q;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Every source differs per channel, so a wrong pick shows at the outputs
    always_comb begin
        for (int ch = 0; ch < N_CH; ch++) begin
            o_tx_clkout[ch]        = cnt_q[ch+1];
            o_rx_clkout[ch]        = cnt_q[ch+1] ^ cnt_q[ch+2];
            o_tx_coreclk[ch]       = ~cnt_q[ch+1];
            o_rx_coreclk[ch]       = ~o_rx_clkout[ch];
            o_tx_data[ch*DW +: DW] = DW'({cnt_q, 4'(ch)});
            o_rx_data[ch*DW +: DW] = DW'({~cnt_q, 4'(ch)});
        end
    end
endmodule : pfc_fabric_model

// ===== pfc_pkg.sv
// Constants for the phase compensation FIFO core clock selector
// Function
// - Transmit FIFO writes from the fabric use the selected transmitter core clock.
// - Receive FIFO reads toward the fabric use the selected receiver core clock.
// - Fabric transmit clock matches transmit output clock frequency and overrides other options.
// - Fabric receive clock matches receive output clock frequency and overrides other options.
// - Shared transmit option: channel 0 transmit clock writes every channel's FIFO.
// - Per-channel transmit option: own transmit clock writes own FIFO.
// - Shared receive option: channel 0 transmit clock reads every receive FIFO.
// - Second receive option: own transmit clock reads own receive FIFO.
// - Third receive option: own receive clock reads own receive FIFO.
package pfc_pkg;
    localparam int          AXI_AW          = 4;
    localparam int          AXI_DW          = 32;
    localparam logic [3:0]  ADDR_CFG        = 4'h0;
    localparam logic [3:0]  ADDR_APPLY      = 4'h4;
    localparam logic [3:0]  ADDR_STATUS     = 4'h8;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    // Configuration and apply register fields
    localparam int          CFG_TX_SEL_BIT  = 0;
    localparam int          CFG_RX_SEL_LSB  = 1;
    localparam int          CFG_TX_CORE_BIT = 4;
    localparam int          CFG_RX_CORE_BIT = 5;
    localparam int          CFG_WIDTH       = 6;
    localparam logic [5:0]  CFG_RESET       = 6'h02;
    localparam int          APPLY_BIT       = 0;
    // Status register fields
    localparam int          ST_TX_LSB       = 0;
    localparam int          ST_RX_LSB       = 4;
    localparam int          ST_BAD_BIT      = 8;
    localparam int          ST_CNT_LSB      = 16;
    // Encoded option codes
    localparam logic [1:0]  RX_CODE_SHARED  = 2'h0;
    localparam logic [1:0]  RX_CODE_OWN_TX  = 2'h1;
    localparam logic [1:0]  RX_CODE_OWN_RX  = 2'h2;
    // One-hot selections, one bit per clock source
    localparam logic [2:0]  TX_SEL_SHARED   = 3'h1;
    localparam logic [2:0]  TX_SEL_OWN      = 3'h2;
    localparam logic [2:0]  TX_SEL_CORE     = 3'h4;
    localparam logic [3:0]  RX_SEL_SHARED   = 4'h1;
    localparam logic [3:0]  RX_SEL_OWN_TX   = 4'h2;
    localparam logic [3:0]  RX_SEL_OWN_RX   = 4'h4;
    localparam logic [3:0]  RX_SEL_CORE     = 4'h8;
    localparam logic [2:0]  TX_SEL_RESET    = 3'h2;
    localparam logic [3:0]  RX_SEL_RESET    = 4'h4;

    typedef enum logic [1:0] {
        WR_IDLE = 2'h1,
        WR_RESP = 2'h2
    } pfc_wr_state_type;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_DATA = 2'h2
    } pfc_rd_state_type;
endpackage : pfc_pkg
